/* wbs_regs.svh */
// Purpose: Register offsets, field positions, reset values and sizes
// Assumes: Included by bare name from design files
// Notes: All offsets are byte addresses of 32-bit words
`ifndef WBS_REGS_SVH
`define WBS_REGS_SVH

// ==========================================================
// Sizes
`define WBS_ADDR_W 8
`define WBS_SAMPLE_W 20
`define WBS_CHANNELS 16
`define WBS_CH_W 4
`define WBS_DEPTH 256
`define WBS_PTR_W 8
`define WBS_CNT_W 9
`define WBS_RATE_W 24

// ==========================================================
// Offsets
`define WBS_OFF_BRD_CTRL 8'h00
`define WBS_OFF_BUFOPS 8'h04
`define WBS_OFF_RATE_A 8'h08
`define WBS_OFF_RATE_B 8'h0C
`define WBS_OFF_THRESH 8'h10
`define WBS_OFF_DATA 8'h14
`define WBS_OFF_STATUS 8'h18

// ==========================================================
// Board control fields
`define WBS_BRD_SIMUL 0
`define WBS_BRD_RATE_A_EN 1
`define WBS_BRD_RATE_B_EN 2
`define WBS_BRD_ACT_LSB 8
`define WBS_BRD_ACT_MSB 11

// ==========================================================
// Buffer operations fields
`define WBS_OPS_CLEAR 0
`define WBS_OPS_CIRC 1
`define WBS_OPS_CLK_EN 2
`define WBS_OPS_BURST 3
`define WBS_OPS_EXT_CLK 4
`define WBS_OPS_EXT_TRIG 5

// ==========================================================
// Data word and status fields
`define WBS_DATA_TAG 24
`define WBS_ST_THRESH 16
`define WBS_ST_EMPTY 17
`define WBS_ST_FULL 18
`define WBS_ST_BURST 19
`define WBS_ST_UNDERRUN 20
`define WBS_ST_OVERFLOW 21

// ==========================================================
// Reset values and response codes
`define WBS_RST_BRD_CTRL 32'h00000000
`define WBS_RST_BUFOPS 32'h00000000
`define WBS_RST_RATE 24'h000001
`define WBS_RST_THRESH 9'h000
`define WBS_RESP_OKAY 2'b00
`define WBS_RESP_SLVERR 2'b10

`endif

/* wbs_pkg.sv */
// Purpose: Types shared by the waveform buffer sequencer
// Assumes: Constants come from wbs_regs.svh
// Notes: Types only
package wbs_pkg;

  typedef enum logic [1:0] {
    WBS_IDLE = 2'b00,
    WBS_GATHER = 2'b01,
    WBS_APPLY = 2'b10
  } wbs_seq_state_type;

endpackage : wbs_pkg

/* wbs_rate_if.sv */
// Purpose: Control and tick of one rate generator
// Assumes: One clock domain
// Notes: gen side is the generator, user side the sequencer
`timescale 1ns/1ns
`include "wbs_regs.svh"

interface wbs_rate_if;
  logic enable;
  logic [`WBS_RATE_W-1:0] divisor;
  logic tick;

  modport gen (input enable, input divisor, output tick);
  modport user (output enable, output divisor, input tick);
endinterface : wbs_rate_if

/* wbs_rate_gen.sv */
// Purpose: Programmable rate generator, one tick every divisor cycles
// Assumes: Divisor 0 treated as 1
// Notes: Counter restarts while disabled
`timescale 1ns/1ns
`include "wbs_regs.svh"

module wbs_rate_gen
  import wbs_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  wbs_rate_if.gen rate
);

  logic [`WBS_RATE_W-1:0] count_reg;

  // ==========================================================
  // Divider
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      count_reg <= '0;
      rate.tick <= 1'b0;
    end
    else if (!rate.enable)
    begin
      count_reg <= '0;
      rate.tick <= 1'b0;
    end
    else if (count_reg + 24'h000001 >= rate.divisor)
    begin
      count_reg <= '0;
      rate.tick <= 1'b1;
    end
    else
    begin
      count_reg <= count_reg + 24'h000001;
      rate.tick <= 1'b0;
    end
  end

endmodule : wbs_rate_gen

/* wbs_sequencer.sv */
// Purpose: Output sample buffer and sequencer with AXI4-Lite registers
// Assumes: ext_clk_in and ext_trig_in synchronous to core_clk
// Notes: Operation
`timescale 1ns/1ns
`include "wbs_regs.svh"

module wbs_sequencer
  import wbs_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [`WBS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`WBS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_clk_in,
  input wire logic ext_trig_in,
  output logic [`WBS_CHANNELS*`WBS_SAMPLE_W-1:0] dac_out,
  output logic dac_update,
  output logic buf_thresh_flag
);

  // ==========================================================
  // Functions
  function automatic logic is_mapped(input logic [`WBS_ADDR_W-1:0] addr);
    is_mapped = (addr == `WBS_OFF_BRD_CTRL) || (addr == `WBS_OFF_BUFOPS) || (addr == `WBS_OFF_RATE_A) ||
                (addr == `WBS_OFF_RATE_B) || (addr == `WBS_OFF_THRESH) || (addr == `WBS_OFF_DATA) ||
                (addr == `WBS_OFF_STATUS);
  endfunction : is_mapped

  function automatic logic [31:0] merge_strb(input logic [31:0] old_val, input logic [31:0] new_val,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = new_val[i*8 +: 8];
    end
    merge_strb = res;
  endfunction : merge_strb

  // ==========================================================
  // Declarations
  logic [`WBS_ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic wr_do;
  logic [31:0] board_control_reg;
  logic [31:0] bufops_reg;
  logic [`WBS_RATE_W-1:0] rate_a_reg;
  logic [`WBS_RATE_W-1:0] rate_b_reg;
  logic [`WBS_CNT_W-1:0] thresh_reg;
  logic clear_pulse;
  logic push;
  logic pop;
  logic [`WBS_SAMPLE_W:0] mem_reg [`WBS_DEPTH];
  logic [`WBS_PTR_W-1:0] wr_ptr_reg;
  logic [`WBS_PTR_W-1:0] rd_ptr_reg;
  logic [`WBS_PTR_W-1:0] play_ptr_reg;
  logic [`WBS_CNT_W-1:0] count_reg;
  logic circ_q_reg;
  logic [`WBS_PTR_W-1:0] src_ptr;
  logic [`WBS_SAMPLE_W:0] cur_sample;
  logic buf_empty;
  logic buf_full;
  logic underrun_reg;
  logic overflow_reg;
  logic underrun_set;
  logic overflow_set;
  logic [31:0] rd_mux;
  logic ext_clk_q_reg;
  logic ext_trig_q_reg;
  logic sample_tick;
  logic trigger;
  logic burst_active_reg;
  logic burst_done_reg;
  wbs_seq_state_type state_reg;
  logic [`WBS_CH_W-1:0] ch_idx_reg;
  logic [`WBS_CH_W-1:0] act_last;
  logic [`WBS_SAMPLE_W-1:0] stage_reg [`WBS_CHANNELS];
  logic circ;
  logic simul;

  wbs_rate_if rate_bus [2] ();

  assign circ = bufops_reg[`WBS_OPS_CIRC];
  assign simul = board_control_reg[`WBS_BRD_SIMUL];
  assign act_last = board_control_reg[`WBS_BRD_ACT_MSB:`WBS_BRD_ACT_LSB];

  // ==========================================================
  // Rate generators
  assign rate_bus[0].enable = board_control_reg[`WBS_BRD_RATE_A_EN];
  assign rate_bus[0].divisor = rate_a_reg;
  assign rate_bus[1].enable = board_control_reg[`WBS_BRD_RATE_B_EN];
  assign rate_bus[1].divisor = rate_b_reg;

  generate
    for (genvar g = 0; g < 2; g++)
    begin : gen_rate
      wbs_rate_gen u_rate (
        .core_clk(core_clk),
        .resetn(resetn),
        .rate(rate_bus[g])
      );
    end
  endgenerate

  // ==========================================================
  // AXI4-Lite write channel
  assign wr_do = aw_got_reg && w_got_reg && !s_axi_bvalid;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `WBS_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_reg <= s_axi_awaddr;
        aw_got_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      else if (!aw_got_reg && !s_axi_bvalid)
        s_axi_awready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_got_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      else if (!w_got_reg && !s_axi_bvalid)
        s_axi_wready <= 1'b1;
      if (wr_do)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_addr_reg) ? `WBS_RESP_OKAY : `WBS_RESP_SLVERR;
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      board_control_reg <= `WBS_RST_BRD_CTRL;
      bufops_reg <= `WBS_RST_BUFOPS;
      rate_a_reg <= `WBS_RST_RATE;
      rate_b_reg <= `WBS_RST_RATE;
      thresh_reg <= `WBS_RST_THRESH;
    end
    else if (wr_do)
    begin
      if (aw_addr_reg == `WBS_OFF_BRD_CTRL)
        board_control_reg <= merge_strb(board_control_reg, w_data_reg, w_strb_reg);
      if (aw_addr_reg == `WBS_OFF_BUFOPS)
        bufops_reg <= merge_strb(bufops_reg, w_data_reg, w_strb_reg);
      if (aw_addr_reg == `WBS_OFF_RATE_A)
        rate_a_reg <= `WBS_RATE_W'(merge_strb({8'h00, rate_a_reg}, w_data_reg, w_strb_reg));
      if (aw_addr_reg == `WBS_OFF_RATE_B)
        rate_b_reg <= `WBS_RATE_W'(merge_strb({8'h00, rate_b_reg}, w_data_reg, w_strb_reg));
      if (aw_addr_reg == `WBS_OFF_THRESH)
        thresh_reg <= `WBS_CNT_W'(merge_strb({23'h000000, thresh_reg}, w_data_reg, w_strb_reg));
    end
  end

  // Flush bit acts once; it is stored in bufops_reg but reads back as zero
  assign clear_pulse = wr_do && (aw_addr_reg == `WBS_OFF_BUFOPS) && w_strb_reg[0] &&
                       w_data_reg[`WBS_OPS_CLEAR];

  // ==========================================================
  // Buffer storage
  assign buf_empty = (count_reg == '0);
  assign buf_full = (count_reg == `WBS_CNT_W'(`WBS_DEPTH));
  assign push = wr_do && (aw_addr_reg == `WBS_OFF_DATA) && !circ && !buf_full && !clear_pulse;
  assign overflow_set = wr_do && (aw_addr_reg == `WBS_OFF_DATA) && !circ && buf_full;
  assign src_ptr = circ ? play_ptr_reg : rd_ptr_reg;
  assign cur_sample = mem_reg[src_ptr];
  assign pop = (state_reg == WBS_GATHER) && !buf_empty && !circ;

  always_ff @(posedge core_clk)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= {w_data_reg[`WBS_DATA_TAG], w_data_reg[`WBS_SAMPLE_W-1:0]};
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else if (clear_pulse)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 8'h01;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 8'h01;
      if (push && !pop)
        count_reg <= count_reg + 9'h001;
      else if (pop && !push)
        count_reg <= count_reg - 9'h001;
    end
  end

  // Loop pointer walks stored samples without consuming them
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      play_ptr_reg <= '0;
      circ_q_reg <= 1'b0;
    end
    else
    begin
      circ_q_reg <= circ;
      if (clear_pulse || (circ && !circ_q_reg))
        play_ptr_reg <= rd_ptr_reg;
      else if ((state_reg == WBS_GATHER) && circ && !buf_empty)
        play_ptr_reg <= (play_ptr_reg + 8'h01 == wr_ptr_reg) ? rd_ptr_reg : play_ptr_reg + 8'h01;
    end
  end

  // ==========================================================
  // Clock and trigger sources
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ext_clk_q_reg <= 1'b0;
      ext_trig_q_reg <= 1'b0;
    end
    else
    begin
      ext_clk_q_reg <= ext_clk_in;
      ext_trig_q_reg <= ext_trig_in;
    end
  end

  assign sample_tick = bufops_reg[`WBS_OPS_CLK_EN] && (bufops_reg[`WBS_OPS_EXT_CLK] ?
                       (ext_clk_in && !ext_clk_q_reg) : rate_bus[0].tick);
  assign trigger = bufops_reg[`WBS_OPS_EXT_TRIG] ? (ext_trig_in && !ext_trig_q_reg) : rate_bus[1].tick;

  // ==========================================================
  // Burst control
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      burst_active_reg <= 1'b0;
    else if (clear_pulse || !bufops_reg[`WBS_OPS_BURST])
      burst_active_reg <= 1'b0;
    else if (!burst_active_reg && trigger && !buf_empty)
      burst_active_reg <= 1'b1;
    else if (state_reg == WBS_GATHER && buf_empty)
      burst_active_reg <= 1'b0;
    else if (state_reg == WBS_APPLY && burst_done_reg)
      burst_active_reg <= 1'b0;
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= WBS_IDLE;
      ch_idx_reg <= '0;
      burst_done_reg <= 1'b0;
    end
    else if (clear_pulse)
      state_reg <= WBS_IDLE;
    else
    begin
      case (state_reg)
        WBS_IDLE:
        begin
          burst_done_reg <= 1'b0;
          ch_idx_reg <= '0;
          if (sample_tick && !buf_empty && (!bufops_reg[`WBS_OPS_BURST] || burst_active_reg))
            state_reg <= WBS_GATHER;
        end
        WBS_GATHER:
        begin
          if (buf_empty)
            state_reg <= WBS_IDLE;
          else
          begin
            if (cur_sample[`WBS_SAMPLE_W])
              burst_done_reg <= 1'b1;
            if (ch_idx_reg == act_last)
              state_reg <= WBS_APPLY;
            else
              ch_idx_reg <= ch_idx_reg + 4'h1;
          end
        end
        WBS_APPLY:
          state_reg <= WBS_IDLE;
        default:
          state_reg <= WBS_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Channel outputs
  generate
    for (genvar c = 0; c < `WBS_CHANNELS; c++)
    begin : gen_ch
      always_ff @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          stage_reg[c] <= '0;
          dac_out[c*`WBS_SAMPLE_W +: `WBS_SAMPLE_W] <= '0;
        end
        else
        begin
          if (state_reg == WBS_GATHER && !buf_empty && ch_idx_reg == `WBS_CH_W'(c))
            stage_reg[c] <= cur_sample[`WBS_SAMPLE_W-1:0];
          if (state_reg == WBS_GATHER && !buf_empty && !simul && ch_idx_reg == `WBS_CH_W'(c))
            dac_out[c*`WBS_SAMPLE_W +: `WBS_SAMPLE_W] <= cur_sample[`WBS_SAMPLE_W-1:0];
          else if (state_reg == WBS_APPLY && simul && `WBS_CH_W'(c) <= act_last)
            dac_out[c*`WBS_SAMPLE_W +: `WBS_SAMPLE_W] <= stage_reg[c];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      dac_update <= 1'b0;
    else
      dac_update <= simul ? (state_reg == WBS_APPLY) : (state_reg == WBS_GATHER && !buf_empty);
  end

  // ==========================================================
  // Status
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      buf_thresh_flag <= 1'b0;
    else
      buf_thresh_flag <= (count_reg >= thresh_reg);
  end

  assign underrun_set = (state_reg == WBS_GATHER) && buf_empty && !burst_active_reg;

  // Set beats a same-cycle write-one clear
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      underrun_reg <= 1'b0;
      overflow_reg <= 1'b0;
    end
    else
    begin
      underrun_reg <= underrun_set || (underrun_reg && !(wr_do && aw_addr_reg == `WBS_OFF_STATUS &&
                      w_strb_reg[2] && w_data_reg[`WBS_ST_UNDERRUN]));
      overflow_reg <= overflow_set || (overflow_reg && !(wr_do && aw_addr_reg == `WBS_OFF_STATUS &&
                      w_strb_reg[2] && w_data_reg[`WBS_ST_OVERFLOW]));
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  always_comb
  begin
    rd_mux = 32'h00000000;
    case (s_axi_araddr)
      `WBS_OFF_BRD_CTRL: rd_mux = board_control_reg;
      `WBS_OFF_BUFOPS: rd_mux = bufops_reg & ~32'h00000001;
      `WBS_OFF_RATE_A: rd_mux = {8'h00, rate_a_reg};
      `WBS_OFF_RATE_B: rd_mux = {8'h00, rate_b_reg};
      `WBS_OFF_THRESH: rd_mux = {23'h000000, thresh_reg};
      `WBS_OFF_STATUS:
      begin
        rd_mux[`WBS_CNT_W-1:0] = count_reg;
        rd_mux[`WBS_ST_THRESH] = buf_thresh_flag;
        rd_mux[`WBS_ST_EMPTY] = buf_empty;
        rd_mux[`WBS_ST_FULL] = buf_full;
        rd_mux[`WBS_ST_BURST] = burst_active_reg;
        rd_mux[`WBS_ST_UNDERRUN] = underrun_reg;
        rd_mux[`WBS_ST_OVERFLOW] = overflow_reg;
      end
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `WBS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? `WBS_RESP_OKAY : `WBS_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

endmodule : wbs_sequencer

/* wbs_seq_monitor.sv */
// Purpose: Port checks for the waveform buffer sequencer
// Assumes: Bound into wbs_sequencer
// Notes: One clock domain
`timescale 1ns/1ns
`include "wbs_regs.svh"

module wbs_seq_monitor
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [`WBS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`WBS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [`WBS_CHANNELS*`WBS_SAMPLE_W-1:0] dac_out,
  input wire logic dac_update
);
  // ==========================================
  // Assertions
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  ready_after_reset_a: assert property ($rose(resetn) |=> s_axi_awready && s_axi_wready && s_axi_arready)
    else $error("bus not ready after reset");
  aw_taken_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("awready stayed high after take");
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_awaddr <= 8'h18 && s_axi_awaddr[1:0] == 2'b00 |-> ##[1:2] s_axi_bvalid && s_axi_bresp == 2'h0)
    else $error("write answer missing or wrong");
  bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid held after handshake");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##[0:1] s_axi_rvalid)
    else $error("read answer missing");
  rvalid_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid held after handshake");
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h18
    |=> ##[0:1] s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  dac_change_a: assert property ($changed(dac_out) |-> dac_update)
    else $error("outputs changed without update");

  cover property (dac_update);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule : wbs_seq_monitor

/* wbs_host_model.sv */
// Purpose: Host software model, AXI4-Lite master
// Assumes: Tasks called from the bench
// Notes: Released payload shows inverted value
`timescale 1ns/1ns
`include "wbs_regs.svh"

module wbs_host_model
(
  input wire logic core_clk,
  output logic [`WBS_ADDR_W-1:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [`WBS_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // ==========================================
  // Bus cycles
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge core_clk);
      if (!aw && s_axi_awready === 1'b1)
      begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (!w && s_axi_wready === 1'b1)
      begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : wbs_host_model

/* waveform_buffer_sequencer_tb.sv */
// Purpose: Self-checking bench for the sequencer
// Assumes: Host model drives the register bus
// Notes: Two active channels, both update modes
`timescale 1ns/1ns
`include "wbs_regs.svh"

module waveform_buffer_sequencer_tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic ext_clk_in = 1'b0;
  logic ext_trig_in = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, dac_update, buf_thresh_flag;
  logic [`WBS_CHANNELS*`WBS_SAMPLE_W-1:0] dac_out;
  int n_fail = 0;
  int checks = 0;

  always #10 core_clk = ~core_clk;

  wbs_sequencer i_wbs_sequencer (.*);
  wbs_host_model i_wbs_host_model (.*);

  // ==========================================
  // Helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    i_wbs_host_model.wr(a, d, r);
    chk(32'(r), 32'h0);
  endtask : wreg

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    i_wbs_host_model.rd(a, d, r);
    chk(d & m, e);
  endtask : rchk

  task automatic push(input logic [19:0] v, input logic t);
    wreg(8'h14, {7'h00, t, 4'h0, v});
  endtask : push

  // Waits for one update, then compares both channels
  task automatic upd(input logic [19:0] e0, input logic [19:0] e1, output int n);
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (dac_update !== 1'b1 && n < 300);
    chk(32'(dac_update), 32'h1);
    chk(32'(dac_out[19:0]), 32'(e0));
    chk(32'(dac_out[39:20]), 32'(e1));
  endtask : upd

  task automatic quiet(input int k);
    repeat (k)
    begin
      @(posedge core_clk);
      chk(32'(dac_update), 32'h0);
    end
  endtask : quiet

  task automatic trig;
    @(posedge core_clk);
    ext_trig_in <= 1'b1;
    @(posedge core_clk);
    ext_trig_in <= 1'b0;
  endtask : trig

  // ==========================================
  // Scenarios
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rchk(8'h00, 32'hFFFFFFFF, 32'h00000000);
    rchk(8'h08, 32'hFFFFFFFF, 32'h00000001);
    rchk(8'h0C, 32'hFFFFFFFF, 32'h00000001);
    rchk(8'h18, 32'hFFFFFFFF, 32'h00030000);
    i_wbs_host_model.wr(8'h40, 32'hFFFFFFFF, r);
    chk(32'(r), 32'h2);
    i_wbs_host_model.rd(8'h40, d, r);
    chk(32'(r), 32'h2);
    chk(d, 32'h0);
  endtask : t_regs

  task automatic t_open;
    int n;
    wreg(8'h08, 32'h00000008);
    wreg(8'h00, 32'h00000103);
    push(20'h12345, 1'b0);
    push(20'h6789A, 1'b0);
    quiet(20);
    wreg(8'h04, 32'h00000004);
    upd(20'h12345, 20'h6789A, n);
    wreg(8'h04, 32'h00000000);
    rchk(8'h18, 32'h000301FF, 32'h00030000);
  endtask : t_open

  task automatic t_thresh;
    wreg(8'h10, 32'h00000003);
    push(20'h00001, 1'b0);
    push(20'h00002, 1'b0);
    rchk(8'h18, 32'h000101FF, 32'h00000002);
    chk(32'(buf_thresh_flag), 32'h0);
    push(20'h00003, 1'b0);
    rchk(8'h18, 32'h000101FF, 32'h00010003);
    wreg(8'h04, 32'h00000001);
    rchk(8'h18, 32'h000301FF, 32'h00020000);
    wreg(8'h10, 32'h00000000);
  endtask : t_thresh

  task automatic t_loop;
    int n;
    push(20'hA0000, 1'b0);
    push(20'hA0001, 1'b0);
    push(20'hB0000, 1'b0);
    push(20'hB0001, 1'b1);
    wreg(8'h04, 32'h00000006);
    upd(20'hA0000, 20'hA0001, n);
    upd(20'hB0000, 20'hB0001, n);
    chk(32'(n), 32'h8);
    upd(20'hA0000, 20'hA0001, n);
    rchk(8'h18, 32'h000001FF, 32'h00000004);
    wreg(8'h04, 32'h00000000);
    wreg(8'h04, 32'h00000001);
  endtask : t_loop

  task automatic t_burst;
    int n;
    push(20'hA0000, 1'b0);
    push(20'hA0001, 1'b1);
    push(20'hB0000, 1'b0);
    push(20'hB0001, 1'b1);
    wreg(8'h04, 32'h0000002C);
    quiet(30);
    trig;
    upd(20'hA0000, 20'hA0001, n);
    quiet(40);
    rchk(8'h18, 32'h000001FF, 32'h00000002);
    trig;
    upd(20'hB0000, 20'hB0001, n);
    wreg(8'h04, 32'h00000000);
    wreg(8'h04, 32'h00000001);
  endtask : t_burst

  task automatic t_rate;
    int n;
    push(20'hC0000, 1'b0);
    push(20'hC0001, 1'b1);
    wreg(8'h0C, 32'h00000040);
    wreg(8'h00, 32'h00000107);
    wreg(8'h04, 32'h0000000E);
    upd(20'hC0000, 20'hC0001, n);
    upd(20'hC0000, 20'hC0001, n);
    chk(32'(n), 32'h40);
    wreg(8'h04, 32'h00000000);
  endtask : t_rate

  // Sequential mode on the external clock: one channel per cycle
  task automatic t_seq;
    int n;
    wreg(8'h04, 32'h00000001);
    wreg(8'h00, 32'h00000102);
    push(20'h11111, 1'b0);
    push(20'h22222, 1'b0);
    wreg(8'h04, 32'h00000014);
    ext_clk_in <= 1'b1;
    @(posedge core_clk);
    ext_clk_in <= 1'b0;
    upd(20'h11111, 20'hC0001, n);
    upd(20'h11111, 20'h22222, n);
    chk(32'(n), 32'h1);
  endtask : t_seq

  task automatic complete_run;
    if (n_fail == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    t_regs;
    t_open;
    t_thresh;
    t_loop;
    t_burst;
    t_rate;
    t_seq;
    complete_run;
  end

  // Tests need about 600 cycles
  initial
  begin
    #400000;
    n_fail++;
    complete_run;
  end
endmodule : waveform_buffer_sequencer_tb

bind wbs_sequencer wbs_seq_monitor i_wbs_seq_monitor (.*);
